// [verilog/interrupt_source_vector_map.sv]
/*
  Interrupt source front end with vector and priority mapping:
  one edge pin, eight sensed request pins, peripheral requests,
  register port and arbitration toward the CPU.
  Assumes one 20 MHz clock, a synchronous reset and a CPU that
  pulses an acknowledge for the vector it takes.
*/
// The placing of the registers and the address-and-strobe port were left to the implementer.
// Function
// - Nine external sources and eight peripheral sources (inputs 7..0 of the 43) are taken in.
// - Only the edge pin and pins 2..0 can wake from standby.
// - The edge pin wins over all and ignores the CPU mask.
// - An edge-select bit picks rising or falling edge of that pin.
// - The edge pin uses vector 7.
// - Each request pin has its own sense setting.
// - Each request pin has an enable; disabled ones are not forwarded.
// - Pin and peripheral levels come from the priority fields.
// - Each request pin has a pending flag that software may clear.
// - Request pin n uses vector 16 plus n.
// - Detection works whatever the pin direction is.
// - A peripheral requests only when its flag and enable are 1.
// - Transfer-controller activation leaves mask and control mode alone.
// - Lower vector number wins under default priorities.
// - Equal levels are decided by fixed vector order.
// - Vector address is twice or four times the vector number.
// - Transfer end uses vector 24, level from third register bits 2..0.
// - Conversion end uses vector 28, level from fifth register bits 2..0.
// - Timer 0 sources use vectors 32..36, sixth register bits 6..4.
// - Each pin and peripheral level runs from 0 lowest to 7 highest.
// - A winner is requested only above the CPU mask level.
// - Sense code BA: 00 low, 01 fall, 10 rise, 11 both.
// - A flag clears by reading 1 then writing 0; writing 1 does nothing.
`timescale 1ns/1ps
`include "irq_map_regs.svh"
module interrupt_source_vector_map (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // Register port
  input  wire irq_map_pkg::addr_type reg_addr,
  input  wire irq_map_pkg::word_type reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output irq_map_pkg::word_type      reg_rdata,
  // Pins
  input  wire logic                  nmi_pin,
  input  wire logic [7:0]            request_pin_n,
  // Peripheral sources
  input  wire logic [42:0]           periph_flag,
  input  wire logic [42:0]           periph_enable,
  // CPU side
  input  wire irq_map_pkg::level_type cpu_mask_level,
  input  wire logic                  advanced_mode,
  input  wire logic                  cpu_ack,
  input  wire logic                  xfer_ack,
  output logic                       cpu_request,
  output irq_map_pkg::vector_type    cpu_vector,
  output logic [3:0]                 cpu_level,
  output irq_map_pkg::word_type      vector_address,
  // Standby
  output logic                       wake_request
);
  import irq_map_pkg::*;

  localparam int NSRC = 17;

  // ========================================================
  // Storage
  logic          nmi_edge_r;
  logic [15:0]   sense_r;
  logic [7:0]    enable_r;
  logic [7:0]    armed_r;
  logic [7:0]    prio_r [0:5];
  word_type      rdata_r;
  logic          nmi_meta_r;
  logic          nmi_sync_r;
  logic          nmi_prev_r;
  logic          nmi_flag_r;
  logic          request_r;
  vector_type    vector_r;
  logic [3:0]    level_r;
  word_type      address_r;
  logic          wake_r;

  pin_event_if pin_ev ();

  // ========================================================
  // Request pin detector
  pin_request_detect u_detect (
    .mclk          (mclk),
    .reset         (reset),
    .request_pin_n (request_pin_n),
    .ev            (pin_ev.detect)
  );

  // ========================================================
  // Helpers
  function automatic level_type field_of(input logic [7:0] r,
                                         input logic hi);
    field_of = hi ? r[`PRIO_HI_MSB -: 3] : r[`PRIO_LO_MSB -: 3];
  endfunction : field_of

  function automatic vector_type vec_of(input int i);
    if (i == 0)
      vec_of = `VEC_NMI;
    else if (i <= 8)
      vec_of = `VEC_PIN_BASE + 7'(i - 1);
    else if (i == 9)
      vec_of = `VEC_XFER_END;
    else if (i == 10)
      vec_of = `VEC_WATCHDOG;
    else if (i == 11)
      vec_of = `VEC_CONV_END;
    else
      vec_of = `VEC_TIMER0_BASE + 7'(i - 12);
  endfunction : vec_of

  // ========================================================
  // Register decode
  wire hit_sys    = reg_addr == `OFS_SYSTEM_CONTROL;
  wire hit_sense  = reg_addr == `OFS_PIN_SENSE;
  wire hit_enable = reg_addr == `OFS_PIN_ENABLE;
  wire hit_status = reg_addr == `OFS_PIN_STATUS;
  wire hit_cur    = reg_addr == `OFS_CURRENT;
  wire hit_prio   = reg_addr >= `OFS_PRIORITY_A &&
                    reg_addr <= `OFS_PRIORITY_F;
  wire [2:0] prio_idx = 3'(reg_addr - `OFS_PRIORITY_A);

  wire [7:0] pin_flag  = pin_ev.flag;
  wire [7:0] pin_level = pin_ev.level;

  // Software clear needs an earlier read of 1
  wire [7:0] sw_clear = (reg_write && hit_status) ?
                        armed_r & ~reg_wdata[7:0] : 8'h00;

  word_type read_mux;
  assign read_mux =
    hit_sys    ? 16'({nmi_edge_r, 3'h0}) :
    hit_sense  ? sense_r :
    hit_enable ? {8'h00, enable_r} :
    hit_status ? {8'h00, pin_flag} :
    hit_prio   ? {8'h00, prio_r[prio_idx]} :
    hit_cur    ? {request_r, 4'h0, level_r, vector_r} :
                 16'h0000;

  // ========================================================
  // Edge pin
  wire nmi_edge = nmi_edge_r ? (~nmi_prev_r & nmi_sync_r)
                             : (nmi_prev_r & ~nmi_sync_r);

  // ========================================================
  // Acknowledge clears
  wire any_ack   = cpu_ack | xfer_ack;
  wire nmi_clear = any_ack && vector_r == `VEC_NMI;

  logic [7:0] ack_clear;
  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_ack
      wire is_low = sense_r[2*p+1:2*p] == `SENSE_LOW;
      // Level mode keeps the flag while the pin is still low
      assign ack_clear[p] = any_ack &&
        vector_r == `VEC_PIN_BASE + 7'(p) &&
        (!is_low || pin_level[p]);
    end
  endgenerate

  assign pin_ev.sense = sense_r;
  assign pin_ev.clear = sw_clear | ack_clear;

  // ========================================================
  // Source table, indexed in vector order
  logic [NSRC-1:0] src_req;
  logic [3:0]      src_lvl [0:NSRC-1];
  wire  [42:0]     periph_req = periph_flag & periph_enable;

  assign src_req[0] = nmi_flag_r;
  assign src_lvl[0] = `NMI_LEVEL;

  generate
    for (p = 0; p < 8; p++) begin : g_src_pin
      localparam int RIX = (p < 2) ? 0 : 1 + (p - 2) / 4;
      localparam bit HI  = (p < 2) ? (p == 0) : (((p - 2) / 2) % 2 == 0);
      assign src_req[p+1] = pin_flag[p] & enable_r[p];
      assign src_lvl[p+1] = {1'b0, field_of(prio_r[RIX], HI)};
    end
  endgenerate

  assign src_req[9]  = periph_req[0];
  assign src_lvl[9]  = {1'b0, field_of(prio_r[2], 1'b0)};
  assign src_req[10] = periph_req[1];
  assign src_lvl[10] = {1'b0, field_of(prio_r[3], 1'b1)};
  assign src_req[11] = periph_req[2];
  assign src_lvl[11] = {1'b0, field_of(prio_r[4], 1'b0)};

  generate
    for (p = 0; p < 5; p++) begin : g_src_tmr
      assign src_req[12+p] = periph_req[3+p];
      assign src_lvl[12+p] = {1'b0, field_of(prio_r[5], 1'b1)};
    end
  endgenerate

  // ========================================================
  // Arbitration; only table vectors, or 0 when no source requests, can come out
  logic       win_found;
  logic [3:0] win_lvl;
  vector_type win_vec;

  always_comb begin
    win_found = 1'b0;
    win_lvl   = 4'h0;
    win_vec   = 7'h00;
    for (int i = 0; i < NSRC; i++) begin
      // Strictly greater: an equal level keeps the lower vector
      if (src_req[i] && (!win_found || src_lvl[i] > win_lvl)) begin
        win_found = 1'b1;
        win_lvl   = src_lvl[i];
        win_vec   = vec_of(i);
      end
    end
  end

  // Edge pin level 8 always clears any 3-bit mask
  wire take = win_found && win_lvl > {1'b0, cpu_mask_level};

  wire [15:0] addr_nxt = advanced_mode ? 16'({win_vec, 2'b00})
                                       : 16'({win_vec, 1'b0});

  wire wake_nxt = nmi_flag_r ||
                  |(pin_flag[2:0] & enable_r[2:0]);

  // ========================================================
  // Register writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      nmi_edge_r <= 1'b0;
      sense_r    <= `SENSE_RESET;
      enable_r   <= `ENABLE_RESET;
      for (int i = 0; i < 6; i++) begin
        prio_r[i] <= `PRIORITY_RESET;
      end
    end else if (reg_write) begin
      if (hit_sys) begin
        nmi_edge_r <= reg_wdata[`NMI_EDGE_BIT];
      end
      if (hit_sense) begin
        sense_r <= reg_wdata;
      end
      if (hit_enable) begin
        enable_r <= reg_wdata[7:0];
      end
      if (hit_prio) begin
        prio_r[prio_idx] <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
      end
    end
  end

  // ========================================================
  // Read data and clear arming
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_r <= 16'h0000;
      armed_r <= 8'h00;
    end else begin
      rdata_r <= reg_read ? read_mux : 16'h0000;
      if (reg_read && hit_status) begin
        armed_r <= (armed_r | pin_flag) & ~sw_clear;
      end else begin
        armed_r <= armed_r & pin_flag & ~sw_clear;
      end
    end
  end

  // ========================================================
  // Edge pin sync and flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      nmi_meta_r <= 1'b1;
      nmi_sync_r <= 1'b1;
      nmi_prev_r <= 1'b1;
      nmi_flag_r <= 1'b0;
    end else begin
      nmi_meta_r <= nmi_pin;
      nmi_sync_r <= nmi_meta_r;
      nmi_prev_r <= nmi_sync_r;
      nmi_flag_r <= (nmi_flag_r & ~nmi_clear) | nmi_edge;
    end
  end

  // ========================================================
  // CPU side outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      request_r <= 1'b0;
      vector_r  <= 7'h00;
      level_r   <= 4'h0;
      address_r <= 16'h0000;
      wake_r    <= 1'b0;
    end else begin
      request_r <= take;
      vector_r  <= win_vec;
      level_r   <= win_lvl;
      address_r <= addr_nxt;
      wake_r    <= wake_nxt;
    end
  end

  assign reg_rdata      = rdata_r;
  assign cpu_request    = request_r;
  assign cpu_vector     = vector_r;
  assign cpu_level      = level_r;
  assign vector_address = address_r;
  assign wake_request   = wake_r;
endmodule : interrupt_source_vector_map

// [verilog/irq_map_regs.svh]
/*
  Register offsets, field positions, reset values and vector numbers
  of the interrupt source and vector map. Assumes an 8-bit register
  address and 16-bit register data.
*/
`ifndef IRQ_MAP_REGS_SVH
`define IRQ_MAP_REGS_SVH

// ==========================================================
// Offsets
`define OFS_SYSTEM_CONTROL 8'h00
`define OFS_PIN_SENSE      8'h01
`define OFS_PIN_ENABLE     8'h02
`define OFS_PIN_STATUS     8'h03
`define OFS_PRIORITY_A     8'h04
`define OFS_PRIORITY_F     8'h09
`define OFS_CURRENT        8'h0A

// ==========================================================
// Fields and reset values
`define NMI_EDGE_BIT       3
`define PRIO_HI_MSB        6
`define PRIO_LO_MSB        2
`define PRIORITY_RESET     8'h77
`define SENSE_RESET        16'h0000
`define ENABLE_RESET       8'h00
`define SENSE_LOW          2'h0
`define SENSE_FALL         2'h1
`define SENSE_RISE         2'h2
`define SENSE_BOTH         2'h3

// ==========================================================
// Vector numbers and edge pin level
`define VEC_NMI            7'h07
`define VEC_PIN_BASE       7'h10
`define VEC_XFER_END       7'h18
`define VEC_WATCHDOG       7'h19
`define VEC_CONV_END       7'h1C
`define VEC_TIMER0_BASE    7'h20
`define NMI_LEVEL          4'h8

`endif

// [verilog/irq_map_pkg.sv]
/*
  Shared types of the interrupt source and vector map.
  Assumes nothing of its surroundings.
*/
package irq_map_pkg;
  typedef logic [2:0]  level_type;
  typedef logic [6:0]  vector_type;
  typedef logic [15:0] word_type;
  typedef logic [7:0]  addr_type;
endpackage : irq_map_pkg

// [verilog/pin_event_if.sv]
/*
  Carrier between the register side and the request pin detector.
  Assumes both ends run on mclk.
*/
`timescale 1ns/1ps
interface pin_event_if;
  logic [7:0]  level;
  logic [15:0] sense;
  logic [7:0]  clear;
  logic [7:0]  flag;
  modport detect  (input sense, input clear, output level, output flag);
  modport control (output sense, output clear, input level, input flag);
endinterface : pin_event_if

// [verilog/pin_request_detect.sv]
/*
  Synchronises the eight request pins, detects level or edges as
  each pin's sense field selects, and holds the pending flags.
  Assumes asynchronous pins, idle high.
*/
`timescale 1ns/1ps
`include "irq_map_regs.svh"
module pin_request_detect (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Pins, active low
  input wire logic [7:0] request_pin_n,
  // Register side
  pin_event_if.detect    ev
);
  import irq_map_pkg::*;

  logic [7:0] meta_r;
  logic [7:0] sync_r;
  logic [7:0] prev_r;
  logic [7:0] flag_r;
  logic [7:0] flag_nxt;
  wire  [7:0] set_w;

  // ========================================================
  // Sense decode; pin direction is never looked at
  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_pin
      wire [1:0] mode_w = ev.sense[2*n+1:2*n];
      assign set_w[n] =
        (mode_w == `SENSE_LOW)  ? ~sync_r[n] :
        (mode_w == `SENSE_FALL) ? prev_r[n] & ~sync_r[n] :
        (mode_w == `SENSE_RISE) ? ~prev_r[n] & sync_r[n] :
                                  prev_r[n] ^ sync_r[n];
    end
  endgenerate

  // A new request beats a clear in the same cycle
  assign flag_nxt = (flag_r & ~ev.clear) | set_w;
  assign ev.level = sync_r;
  assign ev.flag  = flag_r;

  // ========================================================
  // Flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= 8'hFF;
      sync_r <= 8'hFF;
      prev_r <= 8'hFF;
      flag_r <= 8'h00;
    end else begin
      meta_r <= request_pin_n;
      sync_r <= meta_r;
      prev_r <= sync_r;
      flag_r <= flag_nxt;
    end
  end
endmodule : pin_request_detect

// [test/vector_map_chk.sv]
/*
  Port assertions for the interrupt source and vector map.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module vector_map_chk (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    reset,
  // Watched ports
  input wire logic                    reg_read,
  input wire irq_map_pkg::word_type   reg_rdata,
  input wire logic [42:0]             periph_flag,
  input wire logic [42:0]             periph_enable,
  input wire irq_map_pkg::level_type  cpu_mask_level,
  input wire logic                    advanced_mode,
  input wire logic                    cpu_ack,
  input wire logic                    xfer_ack,
  input wire logic                    cpu_request,
  input wire irq_map_pkg::vector_type cpu_vector,
  input wire logic [3:0]              cpu_level,
  input wire irq_map_pkg::word_type   vector_address
);
  import irq_map_pkg::*;
  wire logic [42:0] preq = periph_flag & periph_enable;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Properties
  property p_rdata; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
  property p_nmi; cpu_vector == 7'h07 |-> cpu_request && cpu_level == 4'h8; endproperty
  property p_addr;
    $stable(advanced_mode) |-> vector_address ==
      (advanced_mode ? {7'h00, cpu_vector, 2'h0} : {8'h00, cpu_vector, 1'h0});
  endproperty
  // Mask change needs a cycle to reach the registered winner
  property p_mask;
    cpu_request && cpu_vector != 7'h07 && $stable(cpu_mask_level)
      |-> cpu_level > {1'h0, cpu_mask_level};
  endproperty
  property p_level; cpu_request && cpu_vector != 7'h07 |-> !cpu_level[3]; endproperty
  property p_reserved;
    cpu_request |-> !(cpu_vector inside {7'h1A, 7'h1B, 7'h1D, 7'h1E, 7'h1F, 7'h25, 7'h26, 7'h27});
  endproperty
  property p_periph;
    cpu_request && cpu_vector == 7'h18 |-> $past(preq[0]) || $past(preq[0], 2);
  endproperty
  property p_ack;
    (cpu_ack || xfer_ack) && cpu_vector == 7'h07 |-> ##2 !(cpu_request && cpu_vector == 7'h07);
  endproperty
  // ==========================================================
  // Assertions
  a_rdata: assert property (p_rdata)
    else $error("read data outside answer cycle");
  a_nmi: assert property (p_nmi)
    else $error("edge pin vector without request or top level");
  a_addr: assert property (p_addr)
    else $error("vector address not scaled from vector");
  a_mask: assert property (p_mask)
    else $error("request at or below mask level");
  a_level: assert property (p_level)
    else $error("maskable level above seven");
  a_reserved: assert property (p_reserved)
    else $error("reserved vector requested");
  a_periph: assert property (p_periph)
    else $error("transfer end vector without flag and enable");
  a_ack: assert property (p_ack)
    else $error("edge pin request survives acknowledge");
  c_nmi: cover property (cpu_request && cpu_vector == 7'h07);
  c_pin: cover property (cpu_request && cpu_vector == 7'h10);
  c_timer: cover property (cpu_request && cpu_vector == 7'h20);
endmodule : vector_map_chk

bind interrupt_source_vector_map vector_map_chk chk_u (
  .mclk(mclk), .reset(reset), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .periph_flag(periph_flag), .periph_enable(periph_enable),
  .cpu_mask_level(cpu_mask_level), .advanced_mode(advanced_mode),
  .cpu_ack(cpu_ack), .xfer_ack(xfer_ack), .cpu_request(cpu_request),
  .cpu_vector(cpu_vector), .cpu_level(cpu_level), .vector_address(vector_address)
);

// [test/cpu_core_model.sv]
/*
  CPU core and transfer controller stand-in: acknowledges requests.
  Assumes the map's outputs are registered on mclk.
*/
`timescale 1ns/1ps
module cpu_core_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Map side
  input  wire logic       cpu_request,
  output logic            cpu_ack,
  output logic            xfer_ack,
  // Control: 0 idle, 1 cpu, 2 transfer; lag in cycles
  input  wire logic [1:0] mode,
  input  wire logic [3:0] lag
);
  logic [3:0] wait_r;
  logic [1:0] gap_r;
  // Gap keeps acks apart until the winner is refreshed
  always_ff @(posedge mclk) begin
    cpu_ack  <= 1'h0;
    xfer_ack <= 1'h0;
    if (reset) begin
      wait_r <= 4'h0;
      gap_r  <= 2'h0;
    end else if (gap_r != 2'h0) begin
      gap_r <= gap_r - 2'h1;
    end else if (cpu_request && mode != 2'h0) begin
      if (wait_r == lag) begin
        cpu_ack  <= (mode == 2'h1);
        xfer_ack <= (mode == 2'h2);
        wait_r   <= 4'h0;
        gap_r    <= 2'h3;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule : cpu_core_model

// [test/interrupt_source_vector_map_test.sv]
/*
  Self-checking bench of the interrupt source and vector map.
  Assumes the map, its checker and the core model are compiled first.
*/
`timescale 1ns/1ps
module interrupt_source_vector_map_test;
  import irq_map_pkg::*;
  logic        mclk, reset, reg_write, reg_read, nmi_pin, advanced_mode;
  logic        cpu_ack, xfer_ack, cpu_request, wake_request;
  addr_type    reg_addr;
  word_type    reg_wdata, reg_rdata, vector_address, d;
  logic [7:0]  pin_n;
  logic [42:0] periph_flag, periph_enable;
  level_type   cpu_mask_level;
  vector_type  cpu_vector;
  logic [3:0]  cpu_level, lag;
  logic [1:0]  mode, c;
  int          errors, checks;

  interrupt_source_vector_map dut_u (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .nmi_pin(nmi_pin), .request_pin_n(pin_n), .periph_flag(periph_flag),
    .periph_enable(periph_enable), .cpu_mask_level(cpu_mask_level),
    .advanced_mode(advanced_mode), .cpu_ack(cpu_ack), .xfer_ack(xfer_ack),
    .cpu_request(cpu_request), .cpu_vector(cpu_vector), .cpu_level(cpu_level),
    .vector_address(vector_address), .wake_request(wake_request));
  cpu_core_model core_u (.mclk(mclk), .reset(reset), .cpu_request(cpu_request),
    .cpu_ack(cpu_ack), .xfer_ack(xfer_ack), .mode(mode), .lag(lag));

  always #25 mclk = ~mclk;
  // ==========================================================
  // Tasks
  task settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task wr(input addr_type a, input word_type v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'h1;
    @(posedge mclk);
    reg_write <= 1'h0;
  endtask : wr
  task rd(input addr_type a, output word_type v);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge mclk);
    reg_read <= 1'h0;
    // Sample mid-cycle, where the answer has settled
    @(negedge mclk);
    v = reg_rdata;
  endtask : rd
  task chk_w(input string name, input word_type exp, input word_type got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_w
  task chk_o(input logic req, input vector_type vec);
    chk_w("request and vector", {8'h00, req, vec}, {8'h00, cpu_request, cpu_vector});
  endtask : chk_o
  task pcase(input logic [7:0] f, input logic req, input vector_type vec);
    @(posedge mclk);
    periph_flag <= {35'h0, f};
    settle(3);
    chk_o(req, vec);
  endtask : pcase
  task close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
  // ==========================================================
  // Tests
  initial begin
    mclk = 0; reset = 1; reg_write = 0; reg_read = 0; reg_addr = 0; reg_wdata = 0;
    nmi_pin = 1; pin_n = 8'hFF; periph_flag = 0; periph_enable = 0;
    cpu_mask_level = 0; advanced_mode = 0; mode = 0; lag = 0; errors = 0; checks = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    for (int a = 0; a < 10; a++) begin
      rd(a[7:0], d);
      chk_w("reset value", (a >= 4) ? 16'h0077 : 16'h0000, d);
    end
    rd(8'h20, d);
    chk_w("unmapped", 16'h0000, d);
    wr(8'h04, 16'hFFFF);
    rd(8'h04, d);
    chk_w("priority", 16'h0077, d);
    wr(8'h04, 16'h0077);
    $display("test registers done");
    for (int n = 0; n < 8; n++) begin
      c = n[1:0];
      wr(8'h01, word_type'(c) << (2 * n));
      wr(8'h02, 16'h0000);
      @(posedge mclk);
      pin_n[n] <= 1'h0;
      if (c == 2'h2) begin
        settle(2);
        @(posedge mclk);
        pin_n[n] <= 1'h1;
      end
      settle(4);
      chk_w("disabled", 16'h0000, {15'h0000, cpu_request});
      rd(8'h03, d);
      chk_w("flag", 16'h0001 << n, d);
      wr(8'h02, 16'h0001 << n);
      settle(3);
      chk_o(1'h1, vector_type'(16 + n));
      chk_w("wake", {15'h0000, n < 3}, {15'h0000, wake_request});
      chk_w("address", word_type'(2 * (16 + n)), vector_address);
      @(posedge mclk);
      pin_n <= 8'hFF;
      settle(3);
      wr(8'h03, 16'h00FF);
      rd(8'h03, d);
      chk_w("flag kept", 16'h0001 << n, d);
      wr(8'h03, ~(16'h0001 << n) & 16'h00FF);
      settle(2);
      chk_w("cleared", 16'h0000, {15'h0000, cpu_request});
    end
    wr(8'h02, 16'h0000);
    $display("test pins done");
    @(posedge mclk);
    periph_flag <= 43'h001;
    settle(3);
    chk_w("gated", 16'h0000, {15'h0000, cpu_request});
    @(posedge mclk);
    periph_enable <= 43'h0FF;
    pcase(8'hFF, 1'h1, 7'h18);
    wr(8'h06, 16'h0070);
    pcase(8'hFF, 1'h1, 7'h19);
    wr(8'h07, 16'h0000);
    pcase(8'hFF, 1'h1, 7'h1C);
    wr(8'h08, 16'h0000);
    pcase(8'hFF, 1'h1, 7'h20);
    pcase(8'hF0, 1'h1, 7'h21);
    pcase(8'h80, 1'h1, 7'h24);
    wr(8'h09, 16'h0030);
    pcase(8'h81, 1'h1, 7'h24);
    chk_w("level", 16'h0003, {12'h000, cpu_level});
    pcase(8'h01, 1'h0, 7'h18);
    @(posedge mclk);
    cpu_mask_level <= 3'h2;
    pcase(8'h80, 1'h1, 7'h24);
    @(posedge mclk);
    cpu_mask_level <= 3'h3;
    pcase(8'h80, 1'h0, 7'h24);
    $display("test peripherals done");
    @(posedge mclk);
    cpu_mask_level <= 3'h7;
    nmi_pin <= 1'h0;
    settle(4);
    chk_o(1'h1, 7'h07);
    chk_w("edge pin level", 16'h0008, {12'h000, cpu_level});
    @(posedge mclk);
    advanced_mode <= 1'h1;
    settle(2);
    chk_w("address", 16'h001C, vector_address);
    @(posedge mclk);
    advanced_mode <= 1'h0;
    settle(2);
    chk_w("address", 16'h000E, vector_address);
    @(posedge mclk);
    mode <= 2'h1;
    settle(8);
    chk_o(1'h0, 7'h24);
    @(posedge mclk);
    mode <= 2'h0;
    wr(8'h00, 16'h0008);
    rd(8'h00, d);
    chk_w("edge select", 16'h0008, d);
    @(posedge mclk);
    nmi_pin <= 1'h1;
    settle(4);
    chk_o(1'h1, 7'h07);
    @(posedge mclk);
    lag  <= 4'h3;
    mode <= 2'h2;
    settle(10);
    chk_o(1'h0, 7'h24);
    $display("test edge pin done");
    close_out();
  end
endmodule : interrupt_source_vector_map_test
